// ### rtl/tcu_timer8.sv
// tcu_timer8: 8-bit timer/counter with one double-buffered compare channel
// assumes cpu strobes are one-cycle pulses synchronous to core_clk and that
// ioTick / oscTick are one-cycle enables from the prescaler and oscillator
`timescale 1ns/1ps
// Contract
// - counter holds while clock select is zero
// - bottom flag asserts when count equals zero
// - max flag asserts when count equals 255
// - top is 255 or compare value, chosen by mode
// - tick from io clock, or oscillator when async select is one
// - each tick clears, increments or decrements the counter
// - cpu reads and writes count regardless of tick
// - cpu count write beats clear or count in same cycle
// - wave mode bits set sequence and overflow flag setting
// - match sets compare flag on the next tick; here it is set two clocks after the match, whether or not a tick follows
// - enabled compare flag requests interrupt; cleared when serviced
// - writing one clears compare flag; zero leaves it
// - compare double buffered in pwm modes, updated at top or bottom
// - cpu compare access goes to buffer when buffering active
// - force strobe acts on output only in non-pwm modes
// - count write blocks compare match on following tick
// - wave output register kept across mode changes
// - output mode change takes effect at next match
// - nonzero output mode overrides port value with wave output
// - output mode zero leaves wave register untouched on match
// - modes: normal, phase-correct pwm, ctc, fast pwm
// - normal mode overflow set when counter becomes zero
module tcu_timer8 import tcu_pkg::*; (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ioTick,
    input wire logic oscTick,
    input wire logic async_clock_select,
    input wire logic [2:0] clock_select_field,
    input wire logic [1:0] wave_mode_field,
    input wire logic [1:0] output_mode_field,
    input wire logic force_compare_strobe,
    input wire logic countWrite,
    input wire logic [7:0] countWriteData,
    input wire logic compareWrite,
    input wire logic [7:0] compareWriteData,
    input wire logic compareFlagWrite,
    input wire logic overflowFlagWrite,
    input wire logic compare_irq_enable,
    input wire logic overflow_irq_enable,
    input wire logic compareIrqAck,
    input wire logic overflowIrqAck,
    input wire logic portValue,
    output logic [7:0] count_value,
    output logic [7:0] compare_value,
    output logic [7:0] compareReadback,
    output logic compare_flag,
    output logic overflow_flag,
    output logic compareIrq,
    output logic overflowIrq,
    output logic timerBottom,
    output logic timerMax,
    output logic wave_out,
    output logic pinOut,
    output logic timer_tick
);

    tcu_state_t st;
    tcu_state_t next_st;

    function automatic logic isPwm(input logic [1:0] m);
        return m == TCU_PC_PWM || m == TCU_FAST_PWM;
    endfunction : isPwm

    logic tick;
    logic match;
    logic [7:0] nextCount;
    logic [7:0] topValue;
    logic pwm;
    logic ovfSet;
    logic cmpSet;
    logic countDownNext;
    logic waveNext;

    always_comb begin
        pwm = isPwm(wave_mode_field);
        // no source selected stops the counter
        tick = (clock_select_field != TCU_CLK_STOPPED) &&
            (async_clock_select ? oscTick : ioTick);
        topValue = (wave_mode_field == TCU_CTC) ? st.compareValue : TCU_MAX;
        match = st.countValue == st.compareValue;
        nextCount = st.countValue;
        countDownNext = st.countDown;
        ovfSet = 1'b0;
        if (tick) begin
            case (wave_mode_field)
                TCU_NORMAL: begin
                    nextCount = st.countValue + 8'h01;
                    ovfSet = st.countValue == TCU_MAX;
                    countDownNext = 1'b0;
                end
                TCU_CTC: begin
                    nextCount = (st.countValue == topValue) ? TCU_BOTTOM : st.countValue + 8'h01;
                    ovfSet = st.countValue == TCU_MAX;
                    countDownNext = 1'b0;
                end
                TCU_FAST_PWM: begin
                    nextCount = (st.countValue == topValue) ? TCU_BOTTOM : st.countValue + 8'h01;
                    ovfSet = st.countValue == TCU_MAX;
                    countDownNext = 1'b0;
                end
                TCU_PC_PWM: begin
                    // dual slope: turn at top and bottom
                    if (st.countDown) begin
                        nextCount = st.countValue - 8'h01;
                        countDownNext = (st.countValue != 8'h01);
                        ovfSet = st.countValue == 8'h01;
                    end else begin
                        nextCount = st.countValue + 8'h01;
                        countDownNext = (st.countValue == 8'hfe);
                    end
                end
                default: begin
                    nextCount = st.countValue;
                end
            endcase
        end
        cmpSet = tick && match && !st.blockMatch;

        // wave register: matches, force and the fast pwm tick at max act; mode switch keeps it
        waveNext = st.waveReg;
        if (pwm) begin
            if (cmpSet && output_mode_field[1]) begin
                if (wave_mode_field == TCU_FAST_PWM) begin
                    waveNext = output_mode_field[0];
                end else begin
                    waveNext = output_mode_field[0] ^ st.countDown;
                end
            end else if (cmpSet && output_mode_field == TCU_OM_TOGGLE
                    && wave_mode_field == TCU_FAST_PWM) begin
                waveNext = ~st.waveReg;
            end else if (tick && wave_mode_field == TCU_FAST_PWM && output_mode_field[1]
                    && st.countValue == TCU_MAX) begin
                waveNext = ~output_mode_field[0];
            end
        end else if (cmpSet || force_compare_strobe) begin
            case (output_mode_field)
                TCU_OM_NONE: waveNext = st.waveReg;
                TCU_OM_TOGGLE: waveNext = ~st.waveReg;
                TCU_OM_CLEAR: waveNext = 1'b0;
                TCU_OM_SET: waveNext = 1'b1;
                default: waveNext = st.waveReg;
            endcase
        end

        next_st = st;
        next_st.tick = tick;
        next_st.countDown = countDownNext;
        next_st.countValue = nextCount;
        if (countWrite) begin
            next_st.countValue = countWriteData;
        end
        // block lasts until the next tick has been consumed
        if (countWrite) begin
            next_st.blockMatch = 1'b1;
        end else if (tick) begin
            next_st.blockMatch = 1'b0;
        end
        // compare register path
        if (compareWrite) begin
            if (pwm) begin
                next_st.compareBuffer = compareWriteData;
            end else begin
                next_st.compareValue = compareWriteData;
                next_st.compareBuffer = compareWriteData;
            end
        end
        if (pwm && tick) begin
            if ((wave_mode_field == TCU_FAST_PWM && st.countValue == TCU_MAX)
                    || (wave_mode_field == TCU_PC_PWM && st.countValue == TCU_MAX)) begin
                next_st.compareValue = st.compareBuffer;
            end
        end
        // flag set is registered twice, so it appears two clocks after the match, whether or not a tick follows
        next_st.pendMatch = cmpSet;
        if (st.pendMatch) begin
            next_st.compareFlag = 1'b1;
        end else if ((compareFlagWrite || compareIrqAck)) begin
            next_st.compareFlag = 1'b0;
        end
        if (ovfSet) begin
            next_st.overflowFlag = 1'b1;
        end else if (overflowFlagWrite || overflowIrqAck) begin
            next_st.overflowFlag = 1'b0;
        end
        next_st.waveReg = waveNext;
        next_st.pinValue = (output_mode_field != TCU_OM_NONE) ? waveNext : portValue;
        next_st.irqCompare = next_st.compareFlag && compare_irq_enable;
        next_st.irqOverflow = next_st.overflowFlag && overflow_irq_enable;
        next_st.atBottom = next_st.countValue == TCU_BOTTOM;
        next_st.atMax = next_st.countValue == TCU_MAX;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.countValue <= TCU_RST_COUNT;
            st.compareValue <= TCU_RST_COMPARE;
            st.compareBuffer <= TCU_RST_COMPARE;
            st.atBottom <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign count_value = st.countValue;
    assign compare_value = st.compareValue;
    assign compareReadback = st.compareBuffer;
    assign compare_flag = st.compareFlag;
    assign overflow_flag = st.overflowFlag;
    assign compareIrq = st.irqCompare;
    assign overflowIrq = st.irqOverflow;
    assign timerBottom = st.atBottom;
    assign timerMax = st.atMax;
    assign wave_out = st.waveReg;
    assign pinOut = st.pinValue;
    assign timer_tick = st.tick;

    AST_STOPPED_HOLDS: assert property (@(posedge core_clk) disable iff (!resetn)
        clock_select_field == TCU_CLK_STOPPED && !countWrite |=> $stable(count_value))
        else $error("counter moved while stopped");
    AST_BOTTOM_FLAG: assert property (@(posedge core_clk) disable iff (!resetn)
        timerBottom == (count_value == 8'h00)) else $error("bottom flag wrong");
    AST_MAX_FLAG: assert property (@(posedge core_clk) disable iff (!resetn)
        timerMax == (count_value == 8'hff)) else $error("max flag wrong");
    AST_WRITE_WINS: assert property (@(posedge core_clk) disable iff (!resetn)
        countWrite |=> count_value == $past(countWriteData))
        else $error("count write lost");
    AST_NORMAL_INC: assert property (@(posedge core_clk) disable iff (!resetn)
        tick && !countWrite && wave_mode_field == TCU_NORMAL
        |=> count_value == $past(count_value) + 8'h01) else $error("no increment");
    AST_FLAG_AFTER_MATCH: assert property (@(posedge core_clk) disable iff (!resetn)
        cmpSet |=> ##1 compare_flag) else $error("compare flag not set");
    AST_WRITE_BLOCKS: assert property (@(posedge core_clk) disable iff (!resetn)
        countWrite |=> !cmpSet) else $error("match not blocked");
    AST_FLAG_CLEAR: assert property (@(posedge core_clk) disable iff (!resetn)
        compareFlagWrite && !st.pendMatch |=> !compare_flag) else $error("flag not cleared");
    AST_PIN_OVERRIDE: assert property (@(posedge core_clk) disable iff (!resetn)
        output_mode_field != TCU_OM_NONE |=> pinOut == wave_out)
        else $error("pin not overridden");
    AST_OVF_NORMAL: assert property (@(posedge core_clk) disable iff (!resetn)
        tick && !countWrite && wave_mode_field == TCU_NORMAL && count_value == 8'hff
        |=> overflow_flag && count_value == 8'h00) else $error("overflow not set");

    // ctc and phase-correct counting, tick source and overflow flag clear
    AST_CTC_CLEAR: assert property (@(posedge core_clk) disable iff (!resetn)
        tick && !countWrite && wave_mode_field == TCU_CTC && count_value == compare_value
        |=> count_value == 8'h00)
        else $error("ctc did not clear at top");
    AST_PC_DOWN: assert property (@(posedge core_clk) disable iff (!resetn)
        tick && !countWrite && wave_mode_field == TCU_PC_PWM && st.countDown
        |=> count_value == $past(count_value) - 8'h01)
        else $error("no decrement");
    AST_TICK_ASYNC: assert property (@(posedge core_clk) disable iff (!resetn)
        async_clock_select && !oscTick
        |=> !timer_tick)
        else $error("tick without oscillator");
    AST_TICK_SYNC: assert property (@(posedge core_clk) disable iff (!resetn)
        !async_clock_select && !ioTick
        |=> !timer_tick)
        else $error("tick without io clock");
    AST_OVF_CLEAR: assert property (@(posedge core_clk) disable iff (!resetn)
        overflowFlagWrite && !ovfSet
        |=> !overflow_flag)
        else $error("overflow flag not cleared");

    // compare flag and interrupt
    AST_FLAG_NEEDS_MATCH: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(compare_flag)
        |-> $past(cmpSet, 2))
        else $error("compare flag without match");
    AST_SET_WINS: assert property (@(posedge core_clk) disable iff (!resetn)
        st.pendMatch
        |=> compare_flag)
        else $error("pending match lost");
    AST_IRQ_FOLLOWS: assert property (@(posedge core_clk) disable iff (!resetn)
        compareIrq == (compare_flag && $past(compare_irq_enable)))
        else $error("compare irq wrong");
    AST_ACK_CLEARS: assert property (@(posedge core_clk) disable iff (!resetn)
        compareIrqAck && !st.pendMatch
        |=> !compare_flag)
        else $error("ack did not clear flag");

    // compare register buffering
    AST_BUF_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
        tick && isPwm(wave_mode_field) && count_value == TCU_MAX
        |=> compare_value == $past(compareReadback))
        else $error("buffer not loaded at max");
    AST_DIRECT_WRITE: assert property (@(posedge core_clk) disable iff (!resetn)
        compareWrite && !isPwm(wave_mode_field)
        |=> compare_value == $past(compareWriteData))
        else $error("direct compare write lost");
    AST_BUFFERED_WRITE: assert property (@(posedge core_clk) disable iff (!resetn)
        compareWrite && isPwm(wave_mode_field) && !tick
        |=> compareReadback == $past(compareWriteData) && $stable(compare_value))
        else $error("buffered compare write wrong");

    // waveform register
    AST_FORCE_SET: assert property (@(posedge core_clk) disable iff (!resetn)
        force_compare_strobe && !isPwm(wave_mode_field) && output_mode_field == TCU_OM_SET
        |=> wave_out)
        else $error("force did not set output");
    AST_FORCE_CLEAR: assert property (@(posedge core_clk) disable iff (!resetn)
        force_compare_strobe && !isPwm(wave_mode_field) && output_mode_field == TCU_OM_CLEAR
        |=> !wave_out)
        else $error("force did not clear output");
    AST_FORCE_NO_FLAG: assert property (@(posedge core_clk) disable iff (!resetn)
        force_compare_strobe && !st.pendMatch && !compare_flag
        |=> !compare_flag)
        else $error("force set compare flag");
    AST_FORCE_PWM: assert property (@(posedge core_clk) disable iff (!resetn)
        force_compare_strobe && isPwm(wave_mode_field) && !tick
        |=> $stable(wave_out))
        else $error("force acted in pwm mode");
    AST_NONE_KEEPS: assert property (@(posedge core_clk) disable iff (!resetn)
        output_mode_field == TCU_OM_NONE
        |=> $stable(wave_out))
        else $error("wave changed with mode none");
    AST_PORT_PASS: assert property (@(posedge core_clk) disable iff (!resetn)
        output_mode_field == TCU_OM_NONE
        |=> pinOut == $past(portValue))
        else $error("port value not passed");

    // values right after reset release
    AST_RESET_VALUES: assert property (@(posedge core_clk)
        $rose(resetn)
        |-> count_value == 8'h00 && compare_value == 8'h00 && !compare_flag
            && !overflow_flag && !wave_out)
        else $error("reset values wrong");

    COV_CTC_CLEAR: cover property (@(posedge core_clk) tick && wave_mode_field == TCU_CTC
        && count_value == compare_value);
    COV_MATCH: cover property (@(posedge core_clk) cmpSet);
    COV_OVF: cover property (@(posedge core_clk) $rose(overflow_flag));
    COV_FORCE: cover property (@(posedge core_clk) force_compare_strobe && !isPwm(wave_mode_field));
    COV_PCDOWN: cover property (@(posedge core_clk) st.countDown && tick);

endmodule : tcu_timer8

// ### common/tcu_pkg.sv
// tcu_pkg: constants, modes and state carrier for the 8-bit timer/counter
// assumes a single core clock; timer ticks arrive as one-cycle enables
package tcu_pkg;
    localparam int TCU_WIDTH = 8;
    localparam logic [7:0] TCU_BOTTOM = 8'h00;
    localparam logic [7:0] TCU_MAX = 8'hff;
    localparam logic [7:0] TCU_RST_COUNT = 8'h00;
    localparam logic [7:0] TCU_RST_COMPARE = 8'h00;
    localparam logic [2:0] TCU_CLK_STOPPED = 3'h0;

    typedef enum logic [1:0] {
        TCU_NORMAL = 2'b00,
        TCU_PC_PWM = 2'b01,
        TCU_CTC = 2'b10,
        TCU_FAST_PWM = 2'b11
    } tcu_wave_mode_t;

    typedef enum logic [1:0] {
        TCU_OM_NONE = 2'b00,
        TCU_OM_TOGGLE = 2'b01,
        TCU_OM_CLEAR = 2'b10,
        TCU_OM_SET = 2'b11
    } tcu_out_mode_t;

    typedef struct packed {
        logic [7:0] countValue;
        logic [7:0] compareValue;
        logic [7:0] compareBuffer;
        logic countDown;
        logic blockMatch;
        logic pendMatch;
        logic compareFlag;
        logic overflowFlag;
        logic waveReg;
        logic pinValue;
        logic irqCompare;
        logic irqOverflow;
        logic atBottom;
        logic atMax;
        logic tick;
    } tcu_state_t;
endpackage : tcu_pkg

// ### verification/tb_timer8_counter_compare_unit.sv
// tb_timer8_counter_compare_unit: self-checking bench for tcu_timer8
// assumes every strobe has settled at the ports within five idle cycles
`timescale 1ns/1ps
module tb_timer8_counter_compare_unit import tcu_pkg::*; ;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic ioTick = 1'b0, oscTick = 1'b0, async_clock_select = 1'b0;
    logic [2:0] clock_select_field = 3'h1;
    logic [1:0] wave_mode_field = 2'h0, output_mode_field = 2'h0;
    logic force_compare_strobe = 1'b0, countWrite = 1'b0, compareWrite = 1'b0;
    logic [7:0] countWriteData = 8'h00, compareWriteData = 8'h00;
    logic compareFlagWrite = 1'b0, overflowFlagWrite = 1'b0, compare_irq_enable = 1'b1;
    logic overflow_irq_enable = 1'b1, compareIrqAck = 1'b0, overflowIrqAck = 1'b0;
    logic portValue = 1'b0;
    logic [7:0] count_value, compare_value, compareReadback;
    logic compare_flag, overflow_flag, compareIrq, overflowIrq, timerBottom, timerMax;
    logic wave_out, pinOut, timer_tick;
    int mismatches = 0, check_count = 0, mCnt = 0, mCmp = 0, mBuf = 0, i, k;
    bit mCF, mOF, mWave, mBlk, mDown, full = 1'b1;

    always #50 core_clk = ~core_clk;

    tcu_timer8 dut (.core_clk, .resetn, .ioTick, .oscTick, .async_clock_select,
        .clock_select_field, .wave_mode_field, .output_mode_field, .force_compare_strobe,
        .countWrite, .countWriteData, .compareWrite, .compareWriteData, .compareFlagWrite,
        .overflowFlagWrite, .compare_irq_enable, .overflow_irq_enable, .compareIrqAck,
        .overflowIrqAck, .portValue, .count_value, .compare_value, .compareReadback,
        .compare_flag, .overflow_flag, .compareIrq, .overflowIrq, .timerBottom, .timerMax,
        .wave_out, .pinOut, .timer_tick);

    task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk8

    task chk1(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    task check_all;
        chk8("count_value", mCnt[7:0], count_value);
        chk1("timerBottom", mCnt == 0, timerBottom);
        chk1("timerMax", mCnt == 255, timerMax);
        if (!full) chk8("compareReadback", mBuf[7:0], compareReadback);
        if (full) begin
            chk8("compare_value", mCmp[7:0], compare_value);
            chk1("compare_flag", mCF, compare_flag);
            chk1("overflow_flag", mOF, overflow_flag);
            chk1("compareIrq", mCF & compare_irq_enable, compareIrq);
            chk1("overflowIrq", mOF & overflow_irq_enable, overflowIrq);
            chk1("wave_out", mWave, wave_out);
            chk1("pinOut", (output_mode_field != 2'h0) ? mWave : portValue, pinOut);
        end
    endtask : check_all

    task act;
        case (output_mode_field)
            2'h1: mWave = !mWave;
            2'h2: mWave = 1'b0;
            2'h3: mWave = 1'b1;
            default: ;
        endcase
    endtask : act

    task mtick;
        int o;
        o = mCnt;
        if (clock_select_field != 3'h0) begin
            if (mCnt == mCmp && !mBlk) begin
                mCF = 1'b1;
                if (!wave_mode_field[0]) act();
            end
            mBlk = 1'b0;
            case (wave_mode_field)
                2'h1: begin
                    mCnt = mDown ? mCnt - 1 : mCnt + 1;
                    if (mCnt == 255) mDown = 1'b1;
                    if (mCnt == 0) mDown = 1'b0;
                end
                2'h2: mCnt = (mCnt == mCmp) ? 0 : (mCnt + 1) % 256;
                default: mCnt = (mCnt + 1) % 256;
            endcase
            if (!wave_mode_field[0] && o == 255 && mCnt == 0) mOF = 1'b1;
            if (wave_mode_field == 2'h1 && o == 1 && mCnt == 0) mOF = 1'b1;
            if (wave_mode_field[0] && o == 255) mCmp = mBuf;
        end
    endtask : mtick

    task op(input int kind, input logic [7:0] d);
        @(posedge core_clk);
        case (kind)
            0: if (async_clock_select) oscTick <= 1'b1; else ioTick <= 1'b1;
            1: countWrite <= 1'b1;
            2: compareWrite <= 1'b1;
            3: compareFlagWrite <= 1'b1;
            4: overflowFlagWrite <= 1'b1;
            5: force_compare_strobe <= 1'b1;
            6: compareIrqAck <= 1'b1;
            7: overflowIrqAck <= 1'b1;
            8: begin countWrite <= 1'b1; ioTick <= 1'b1; end
            default: if (async_clock_select) ioTick <= 1'b1; else oscTick <= 1'b1;
        endcase
        countWriteData <= d;
        compareWriteData <= d;
        @(posedge core_clk);
        {ioTick, oscTick, countWrite, compareWrite, compareFlagWrite} <= 5'h00;
        {overflowFlagWrite, force_compare_strobe, compareIrqAck, overflowIrqAck} <= 4'h0;
        case (kind)
            0: mtick();
            1, 8: begin mCnt = d; mBlk = 1'b1; end
            2: begin mBuf = d; if (!wave_mode_field[0]) mCmp = d; end
            3, 6: mCF = 1'b0;
            4, 7: mOF = 1'b0;
            5: if (!wave_mode_field[0]) act();
            default: ;
        endcase
        repeat (5) @(posedge core_clk);
        #1;
        check_all();
    endtask : op

    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict

    initial begin
        #5000000;
        mismatches++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h5cc1));
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        #1;
        check_all();
        full = 1'b0;
        @(posedge core_clk);
        wave_mode_field <= 2'h1;
        op(1, 8'hfd);
        op(2, 8'h10);
        repeat (5) op(0, 8'h00);
        chk8("compare_value", 8'h10, compare_value);
        op(3, 8'h00);
        op(4, 8'h00);
        full = 1'b1;
        @(posedge core_clk);
        wave_mode_field <= 2'h2;
        output_mode_field <= 2'h1;
        op(2, 8'h03);
        op(1, 8'h00);
        repeat (6) op(0, 8'h00);
        op(6, 8'h00);
        op(8, 8'h80);
        @(posedge core_clk);
        wave_mode_field <= 2'h0;
        op(0, 8'h00);
        op(1, 8'hfe);
        repeat (2) op(0, 8'h00);
        op(7, 8'h00);
        @(posedge core_clk);
        output_mode_field <= 2'h2;
        op(5, 8'h00);
        @(posedge core_clk);
        wave_mode_field <= 2'h3;
        op(5, 8'h00);
        @(posedge core_clk);
        wave_mode_field <= 2'h0;
        output_mode_field <= 2'h3;
        op(5, 8'h00);
        for (i = 0; i < 300; i++) begin
            @(posedge core_clk);
            clock_select_field <= ($urandom % 4 == 0) ? 3'h0 : 3'($urandom % 7 + 1);
            async_clock_select <= 1'($urandom);
            output_mode_field <= 2'($urandom);
            portValue <= 1'($urandom);
            compare_irq_enable <= 1'($urandom);
            k = $urandom % 12;
            if (k >= 10 || k == 8) k = 0;
            op(k, 8'($urandom % 8));
        end
        print_verdict();
    end
endmodule : tb_timer8_counter_compare_unit
